//--- pkg/pabaf_pkg.sv
/*
 * Shared constants for the port A / port B alternate function override logic.
 * Assumes a single clock domain and a synchronous active-low reset.
 */
package pabaf_pkg;
	localparam int PABAF_PINS = 8;
	localparam logic [7:0] PABAF_READ_RESET = 8'h00;
	localparam logic [7:0] PABAF_ALL_ONES = 8'hFF;
	localparam int PABAF_PB_MISO = 3;
	localparam int PABAF_PB_MOSI = 2;
	localparam int PABAF_PB_SCK = 1;
	localparam int PABAF_PB_SS = 0;
	localparam int PABAF_PB_TIMER0_COMPARE_A_OUT = 7;
	localparam int PABAF_PB_TIMER1_COMPARE_B_OUT = 6;
	localparam int PABAF_PB_TIMER1_COMPARE_A_OUT = 5;
	localparam int PABAF_PB_TIMER2_COMPARE_A_OUT = 4;
endpackage : pabaf_pkg

//--- hdl/pabaf_pad_ctl.sv
/*
 * Generic override resolution for one I/O pin: pull-up, driver enable,
 * driven value and digital input enable.
 * Assumes the override signals come from the alternate functions of the pin.
 */
`timescale 1ns/1ps
module pabaf_pad_ctl (
	input wire logic pullup_override_en,
	input wire logic pullup_override_val,
	input wire logic dir_override_en,
	input wire logic dir_override_val,
	input wire logic value_override_en,
	input wire logic value_override_val,
	input wire logic input_enable_override_en,
	input wire logic input_enable_override_val,
	input wire logic dir_bit,
	input wire logic latch_bit,
	input wire logic global_pullup_disable_term,
	input wire logic sleep,
	input wire logic pad_in,
	output logic pullup_on,
	output logic drive_n,
	output logic pad_out,
	output logic digital_in
);
	logic drive;
	logic input_enable;

	always_comb begin
		if (pullup_override_en) begin
			pullup_on = pullup_override_val;
		end else begin
			pullup_on = ~dir_bit & latch_bit & ~global_pullup_disable_term;
		end
		drive = dir_override_en ? dir_override_val : dir_bit;
		drive_n = ~drive;
		pad_out = value_override_en ? value_override_val : latch_bit;
		input_enable = input_enable_override_en ? input_enable_override_val : ~sleep;
		// A disabled input is clamped low ahead of any synchroniser.
		digital_in = pad_in & input_enable;
	end
endmodule : pabaf_pad_ctl

//--- hdl/pabaf_top.sv
/*
 * Alternate function override logic for two 8-bit ports: port A as the
 * multiplexed low address/data byte of the external memory interface, and
 * port B as timer compare outputs, SPI pins and pin-change sources.
 * Assumes the memory interface, timers, SPI and pin-change logic sit outside
 * and deliver their enables and values in the CLK domain.
 */
`timescale 1ns/1ps
module pabaf_top
	import pabaf_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic SLEEP,
	input wire logic GLOBAL_PULLUP_DISABLE_TERM,
	input wire logic EXT_MEM_ENABLE,
	input wire logic MEM_WRITE,
	input wire logic ADDRESS_PHASE_ACTIVE,
	input wire logic [7:0] MEM_ADDR_LOW,
	input wire logic [7:0] MEM_WDATA,
	output logic [7:0] MEM_RDATA,
	input wire logic [7:0] PORT_A_LATCH,
	input wire logic [7:0] PORT_A_DIR,
	input wire logic [7:0] PA_IN,
	output logic [7:0] PA_OUT,
	output logic [7:0] PA_DRIVE_N,
	output logic [7:0] PA_PULLUP,
	output logic [7:0] PA_READ,
	input wire logic [7:0] PORT_B_LATCH,
	input wire logic [7:0] PORT_B_DIR,
	input wire logic [7:0] PB_IN,
	output logic [7:0] PB_OUT,
	output logic [7:0] PB_DRIVE_N,
	output logic [7:0] PB_PULLUP,
	output logic [7:0] PB_READ,
	input wire logic TIMER0_COMPARE_A_EN,
	input wire logic TIMER0_COMPARE_A_OUT,
	input wire logic TIMER1_COMPARE_C_EN,
	input wire logic TIMER1_COMPARE_C_OUT,
	input wire logic TIMER1_COMPARE_B_EN,
	input wire logic TIMER1_COMPARE_B_OUT,
	input wire logic TIMER1_COMPARE_A_EN,
	input wire logic TIMER1_COMPARE_A_OUT,
	input wire logic TIMER2_COMPARE_A_EN,
	input wire logic TIMER2_COMPARE_A_OUT,
	input wire logic SPI_ENABLE,
	input wire logic SPI_MASTER,
	input wire logic SPI_SLAVE_OUT,
	input wire logic SPI_MASTER_OUT,
	input wire logic SPI_SCK_OUT,
	output logic SPI_MASTER_IN,
	output logic SPI_SLAVE_IN,
	output logic SPI_SCK_IN,
	output logic SPI_SELECT_N_IN,
	input wire logic PIN_CHANGE_GROUP_EN,
	input wire logic [7:0] PIN_CHANGE_MASK,
	output logic [7:0] PIN_CHANGE_SOURCE
);
	logic [7:0] pa_pullup_override_val;
	logic [7:0] pa_value_override_val;
	logic pa_dir_override_val;
	logic [7:0] pa_di;
	logic [7:0] pb_pullup_override_en;
	logic [7:0] pb_pullup_override_val;
	logic [7:0] pb_dir_override_en;
	logic [7:0] pb_value_override_en;
	logic [7:0] pb_value_override_val;
	logic [7:0] pb_input_enable_override_en;
	logic [7:0] pb_di;
	logic spi_master_mode;
	logic spi_slave_mode;
	logic pb7_value;

	assign pa_dir_override_val = MEM_WRITE | ADDRESS_PHASE_ACTIVE;
	assign spi_master_mode = SPI_ENABLE & SPI_MASTER;
	assign spi_slave_mode = SPI_ENABLE & ~SPI_MASTER;
	// Timer 0 takes the pin when both compare outputs are enabled at once.
	assign pb7_value = TIMER0_COMPARE_A_EN ? TIMER0_COMPARE_A_OUT : TIMER1_COMPARE_C_OUT;

	always_comb begin
		pb_pullup_override_en = 8'h00;
		pb_dir_override_en = 8'h00;
		pb_value_override_en = 8'h00;
		pb_value_override_val = 8'h00;
		pb_value_override_en[PABAF_PB_TIMER0_COMPARE_A_OUT] = TIMER0_COMPARE_A_EN | TIMER1_COMPARE_C_EN;
		pb_value_override_val[PABAF_PB_TIMER0_COMPARE_A_OUT] = pb7_value;
		pb_value_override_en[PABAF_PB_TIMER1_COMPARE_B_OUT] = TIMER1_COMPARE_B_EN;
		pb_value_override_val[PABAF_PB_TIMER1_COMPARE_B_OUT] = TIMER1_COMPARE_B_OUT;
		pb_value_override_en[PABAF_PB_TIMER1_COMPARE_A_OUT] = TIMER1_COMPARE_A_EN;
		pb_value_override_val[PABAF_PB_TIMER1_COMPARE_A_OUT] = TIMER1_COMPARE_A_OUT;
		pb_value_override_en[PABAF_PB_TIMER2_COMPARE_A_OUT] = TIMER2_COMPARE_A_EN;
		pb_value_override_val[PABAF_PB_TIMER2_COMPARE_A_OUT] = TIMER2_COMPARE_A_OUT;
		// In master mode the SPI pins are taken over; the slave keeps direction bits.
		for (int i = 0; i < 4; i++) begin
			pb_pullup_override_en[i] = spi_master_mode;
			pb_dir_override_en[i] = spi_master_mode;
		end
		pb_value_override_en[PABAF_PB_MISO] = spi_master_mode;
		pb_value_override_val[PABAF_PB_MISO] = SPI_SLAVE_OUT;
		pb_value_override_en[PABAF_PB_MOSI] = spi_master_mode;
		pb_value_override_val[PABAF_PB_MOSI] = SPI_MASTER_OUT;
		pb_value_override_en[PABAF_PB_SCK] = spi_master_mode;
		pb_value_override_val[PABAF_PB_SCK] = SPI_SCK_OUT;
	end

	assign pb_pullup_override_val = PORT_B_LATCH & {PABAF_PINS{GLOBAL_PULLUP_DISABLE_TERM}};
	assign pb_input_enable_override_en = PIN_CHANGE_MASK & {PABAF_PINS{PIN_CHANGE_GROUP_EN}};

	genvar n;
	generate
		for (n = 0; n < PABAF_PINS; n++) begin : g_pin
			assign pa_pullup_override_val[n] = ~pa_dir_override_val & PORT_A_LATCH[n]
				& GLOBAL_PULLUP_DISABLE_TERM;
			assign pa_value_override_val[n] = (MEM_ADDR_LOW[n] & ADDRESS_PHASE_ACTIVE)
				| (MEM_WDATA[n] & MEM_WRITE);

			pabaf_pad_ctl u_pa (
				.pullup_override_en(EXT_MEM_ENABLE),
				.pullup_override_val(pa_pullup_override_val[n]),
				.dir_override_en(EXT_MEM_ENABLE),
				.dir_override_val(pa_dir_override_val),
				.value_override_en(EXT_MEM_ENABLE),
				.value_override_val(pa_value_override_val[n]),
				.input_enable_override_en(1'b0),
				.input_enable_override_val(1'b0),
				.dir_bit(PORT_A_DIR[n]),
				.latch_bit(PORT_A_LATCH[n]),
				.global_pullup_disable_term(GLOBAL_PULLUP_DISABLE_TERM),
				.sleep(SLEEP),
				.pad_in(PA_IN[n]),
				.pullup_on(PA_PULLUP[n]),
				.drive_n(PA_DRIVE_N[n]),
				.pad_out(PA_OUT[n]),
				.digital_in(pa_di[n])
			);

			pabaf_pad_ctl u_pb (
				.pullup_override_en(pb_pullup_override_en[n]),
				.pullup_override_val(pb_pullup_override_val[n]),
				.dir_override_en(pb_dir_override_en[n]),
				.dir_override_val(1'b0),
				.value_override_en(pb_value_override_en[n]),
				.value_override_val(pb_value_override_val[n]),
				.input_enable_override_en(pb_input_enable_override_en[n]),
				.input_enable_override_val(1'b1),
				.dir_bit(PORT_B_DIR[n]),
				.latch_bit(PORT_B_LATCH[n]),
				.global_pullup_disable_term(GLOBAL_PULLUP_DISABLE_TERM),
				.sleep(SLEEP),
				.pad_in(PB_IN[n]),
				.pullup_on(PB_PULLUP[n]),
				.drive_n(PB_DRIVE_N[n]),
				.pad_out(PB_OUT[n]),
				.digital_in(pb_di[n])
			);
		end
	endgenerate

	// The pad controls stay combinational so bus phases reach the pins at once.
	assign MEM_RDATA = pa_di;
	assign PIN_CHANGE_SOURCE = pb_di;
	assign SPI_MASTER_IN = pb_di[PABAF_PB_MISO];
	assign SPI_SLAVE_IN = pb_di[PABAF_PB_MOSI];
	assign SPI_SCK_IN = pb_di[PABAF_PB_SCK];
	assign SPI_SELECT_N_IN = pb_di[PABAF_PB_SS];

	// Pin read registers sample the gated pad inputs for software.
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			PA_READ <= PABAF_READ_RESET;
		end else begin
			PA_READ <= pa_di;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			PB_READ <= PABAF_READ_RESET;
		end else begin
			PB_READ <= pb_di;
		end
	end

	pa_bus_pullup_a: assert property (@(posedge CLK) disable iff (!NRST)
		(EXT_MEM_ENABLE && (MEM_WRITE || ADDRESS_PHASE_ACTIVE)) |-> (PA_PULLUP == 8'h00))
		else $error("Port A pull-up active during a bus phase.");

	pa_idle_pullup_a: assert property (@(posedge CLK) disable iff (!NRST)
		(EXT_MEM_ENABLE && !MEM_WRITE && !ADDRESS_PHASE_ACTIVE)
		|-> (PA_PULLUP == (PORT_A_LATCH & {8{GLOBAL_PULLUP_DISABLE_TERM}})))
		else $error("Port A idle pull-up differs from latch and pull-up term.");

	pa_bus_drive_a: assert property (@(posedge CLK) disable iff (!NRST)
		EXT_MEM_ENABLE |-> (PA_DRIVE_N == ((MEM_WRITE || ADDRESS_PHASE_ACTIVE) ? 8'h00 : 8'hFF)))
		else $error("Port A driver enable wrong under memory control.");

	pa_addr_out_a: assert property (@(posedge CLK) disable iff (!NRST)
		(EXT_MEM_ENABLE && ADDRESS_PHASE_ACTIVE && !MEM_WRITE) |-> (PA_OUT == MEM_ADDR_LOW))
		else $error("Port A does not show the address during the address phase.");

	pa_data_out_a: assert property (@(posedge CLK) disable iff (!NRST)
		(EXT_MEM_ENABLE && MEM_WRITE && !ADDRESS_PHASE_ACTIVE) |-> (PA_OUT == MEM_WDATA))
		else $error("Port A does not show write data during a write.");

	pa_data_in_a: assert property (@(posedge CLK) disable iff (!NRST)
		EXT_MEM_ENABLE |-> (MEM_RDATA == (PA_IN & {8{!SLEEP}})))
		else $error("Memory read data does not follow port A pins.");

	pa_gpio_dir_a: assert property (@(posedge CLK) disable iff (!NRST)
		!EXT_MEM_ENABLE |-> (PA_DRIVE_N == ~PORT_A_DIR && PA_OUT == PORT_A_LATCH))
		else $error("Port A ignores its direction or latch in plain mode.");

	pa_read_sample_a: assert property (@(posedge CLK) disable iff (!NRST)
		($past(NRST) && $stable(PA_IN) && $stable(SLEEP) && $stable(EXT_MEM_ENABLE))
		|-> (PA_READ == MEM_RDATA))
		else $error("Port A read register lags a steady input.");

	pb7_timer0_a: assert property (@(posedge CLK) disable iff (!NRST)
		(TIMER0_COMPARE_A_EN && PORT_B_DIR[7]) |-> (!PB_DRIVE_N[7] && PB_OUT[7] == TIMER0_COMPARE_A_OUT))
		else $error("Port B pin 7 does not carry timer 0 compare output.");

	pb7_needs_dir_a: assert property (@(posedge CLK) disable iff (!NRST)
		!PORT_B_DIR[7] |-> PB_DRIVE_N[7])
		else $error("Port B pin 7 drives while its direction bit is input.");

	pb_pin_change_a: assert property (@(posedge CLK) disable iff (!NRST)
		pb_input_enable_override_en[7] |-> (PIN_CHANGE_SOURCE[7] == PB_IN[7]))
		else $error("Pin-change source 7 blocked while enabled.");

	pb_spi_master_a: assert property (@(posedge CLK) disable iff (!NRST)
		spi_master_mode |-> (PB_DRIVE_N[3:0] == 4'hF && PB_OUT[PABAF_PB_MOSI] == SPI_MASTER_OUT))
		else $error("SPI master pins not overridden as required.");

	pb_spi_slave_a: assert property (@(posedge CLK) disable iff (!NRST)
		spi_slave_mode |-> (PB_DRIVE_N[0] == !PORT_B_DIR[0]))
		else $error("SPI slave select pin direction not from its direction bit.");
endmodule : pabaf_top

//--- bench/pabaf_ext_mem.sv
/*
 * External memory model on the multiplexed address/data byte of port A.
 * Assumes the bench gives the address strobe, write and read phases.
 */
`timescale 1ns/1ps
module pabaf_ext_mem (
	input wire logic clk,
	input wire logic addr_strobe,
	input wire logic write_phase,
	input wire logic read_phase,
	input wire logic [7:0] pad_out,
	input wire logic [7:0] drive_n,
	input wire logic [7:0] pullup_on,
	output logic [7:0] pad_in,
	output logic [7:0] last_addr
);
	logic [7:0] mem [256];
	logic [7:0] last;
	initial begin
		last = 8'h00;
		last_addr = 8'h00;
	end
	// A released line outside a read phase and without pull-up shows the inverse of its last level.
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			if (!drive_n[n]) begin
				pad_in[n] = pad_out[n];
			end else if (read_phase) begin
				pad_in[n] = mem[last_addr][n];
			end else if (pullup_on[n]) begin
				pad_in[n] = 1'b1;
			end else begin
				pad_in[n] = ~last[n];
			end
		end
	end
	always @(posedge clk) begin
		last <= pad_in;
		if (addr_strobe) begin
			last_addr <= pad_in;
		end
		if (write_phase) begin
			mem[last_addr] <= pad_in;
		end
	end
endmodule : pabaf_ext_mem

//--- bench/tb.sv
/*
 * Self-checking bench for the port A/B override logic with an external memory.
 * Assumes the memory model drives the port A pads; all else comes from here.
 */
`timescale 1ns/1ps
module tb import pabaf_pkg::*;;
	typedef struct packed {
		logic [10:0] spare;
		logic [7:0] mask, b_in, b_dir, b_latch, a_dir, a_latch, wdata, addr;
		logic group, spi_en, spi_mst, spi_so, spi_mo, spi_sck;
		logic t0en, t0v, t1cen, t1cv, t1ben, t1bv, t1aen, t1av, t2en, t2v;
		logic sleep, term, ext, wr, ada;
	} pabaf_stim_t;
	pabaf_stim_t st;
	logic CLK, NRST, rd, run;
	logic SPI_MASTER_IN, SPI_SLAVE_IN, SPI_SCK_IN, SPI_SELECT_N_IN;
	logic [7:0] MEM_RDATA, PA_IN, PA_OUT, PA_DRIVE_N, PA_PULLUP, PA_READ, bus_addr, prev_a;
	logic [7:0] PB_OUT, PB_DRIVE_N, PB_PULLUP, PB_READ, PIN_CHANGE_SOURCE, prev_b;
	logic [7:0] exp_mem [256];
	logic [7:0] aq [$];
	int mismatches, check_count;
	always #2 CLK = ~CLK;
	pabaf_top uut (.CLK(CLK), .NRST(NRST), .SLEEP(st.sleep), .GLOBAL_PULLUP_DISABLE_TERM(st.term),
		.EXT_MEM_ENABLE(st.ext), .MEM_WRITE(st.wr), .ADDRESS_PHASE_ACTIVE(st.ada),
		.MEM_ADDR_LOW(st.addr), .MEM_WDATA(st.wdata), .MEM_RDATA(MEM_RDATA),
		.PORT_A_LATCH(st.a_latch), .PORT_A_DIR(st.a_dir), .PA_IN(PA_IN), .PA_OUT(PA_OUT),
		.PA_DRIVE_N(PA_DRIVE_N), .PA_PULLUP(PA_PULLUP), .PA_READ(PA_READ),
		.PORT_B_LATCH(st.b_latch), .PORT_B_DIR(st.b_dir), .PB_IN(st.b_in), .PB_OUT(PB_OUT),
		.PB_DRIVE_N(PB_DRIVE_N), .PB_PULLUP(PB_PULLUP), .PB_READ(PB_READ),
		.TIMER0_COMPARE_A_EN(st.t0en), .TIMER0_COMPARE_A_OUT(st.t0v),
		.TIMER1_COMPARE_C_EN(st.t1cen), .TIMER1_COMPARE_C_OUT(st.t1cv),
		.TIMER1_COMPARE_B_EN(st.t1ben), .TIMER1_COMPARE_B_OUT(st.t1bv),
		.TIMER1_COMPARE_A_EN(st.t1aen), .TIMER1_COMPARE_A_OUT(st.t1av),
		.TIMER2_COMPARE_A_EN(st.t2en), .TIMER2_COMPARE_A_OUT(st.t2v),
		.SPI_ENABLE(st.spi_en), .SPI_MASTER(st.spi_mst), .SPI_SLAVE_OUT(st.spi_so),
		.SPI_MASTER_OUT(st.spi_mo), .SPI_SCK_OUT(st.spi_sck), .SPI_MASTER_IN(SPI_MASTER_IN),
		.SPI_SLAVE_IN(SPI_SLAVE_IN), .SPI_SCK_IN(SPI_SCK_IN), .SPI_SELECT_N_IN(SPI_SELECT_N_IN),
		.PIN_CHANGE_GROUP_EN(st.group), .PIN_CHANGE_MASK(st.mask),
		.PIN_CHANGE_SOURCE(PIN_CHANGE_SOURCE));
	pabaf_ext_mem ext_mem (.clk(CLK), .addr_strobe(st.ada & st.ext),
		.write_phase(st.wr & st.ext), .read_phase(rd), .pad_out(PA_OUT),
		.drive_n(PA_DRIVE_N), .pullup_on(PA_PULLUP), .pad_in(PA_IN), .last_addr(bus_addr));
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	task automatic check_all();
		logic [7:0] ae, ap, av, sm, be, bp, bv, ga, gb;
		sm = (st.spi_en & st.spi_mst) ? 8'h0F : 8'h00;
		ae = st.ext ? {8{st.wr | st.ada}} : st.a_dir;
		ap = st.ext ? {8{~(st.wr | st.ada)}} & st.a_latch & {8{st.term}}
			: ~st.a_dir & st.a_latch & {8{~st.term}};
		av = st.ext ? (st.addr & {8{st.ada}}) | (st.wdata & {8{st.wr}}) : st.a_latch;
		be = st.b_dir & ~sm;
		bp = (sm & st.b_latch & {8{st.term}}) | (~sm & ~st.b_dir & st.b_latch & {8{~st.term}});
		bv = st.b_latch;
		bv[PABAF_PB_TIMER0_COMPARE_A_OUT] = (st.t0en | st.t1cen) ? (st.t0en ? st.t0v : st.t1cv) : bv[7];
		bv[PABAF_PB_TIMER1_COMPARE_B_OUT] = st.t1ben ? st.t1bv : bv[PABAF_PB_TIMER1_COMPARE_B_OUT];
		bv[PABAF_PB_TIMER1_COMPARE_A_OUT] = st.t1aen ? st.t1av : bv[PABAF_PB_TIMER1_COMPARE_A_OUT];
		bv[PABAF_PB_TIMER2_COMPARE_A_OUT] = st.t2en ? st.t2v : bv[PABAF_PB_TIMER2_COMPARE_A_OUT];
		ga = PA_IN & {8{~st.sleep}};
		gb = st.b_in & ((st.mask & {8{st.group}}) | {8{~st.sleep}});
		cmp("PA_DRIVE_N", ~ae, PA_DRIVE_N);
		cmp("PA_PULLUP", ap, PA_PULLUP);
		cmp("PA_OUT", ae & av, ae & PA_OUT);
		cmp("MEM_RDATA", ga, MEM_RDATA);
		cmp("PB_DRIVE_N", ~be, PB_DRIVE_N);
		cmp("PB_PULLUP", bp, PB_PULLUP);
		cmp("PB_OUT", be & bv, be & PB_OUT);
		cmp("PIN_CHANGE_SOURCE", gb, PIN_CHANGE_SOURCE);
		cmp("SPI inputs", {4'h0, gb[3:0]},
			{4'h0, SPI_MASTER_IN, SPI_SLAVE_IN, SPI_SCK_IN, SPI_SELECT_N_IN});
		cmp("PA_READ", prev_a, PA_READ);
		cmp("PB_READ", prev_b, PB_READ);
		prev_a = NRST ? ga : 8'h00;
		prev_b = NRST ? gb : 8'h00;
	endtask : check_all
	always @(negedge CLK) begin
		if (run) begin
			check_all();
		end
	end
	task automatic put_addr(input logic [7:0] ad);
		@(posedge CLK);
		st.ext <= 1'b1;
		st.sleep <= 1'b0;
		st.wr <= 1'b0;
		st.ada <= 1'b1;
		st.addr <= ad;
		@(negedge CLK);
		cmp("address on pins", ad, PA_OUT);
		@(posedge CLK);
		st.ada <= 1'b0;
	endtask : put_addr
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#40000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		CLK = 1'b0;
		NRST = 1'b0;
		rd = 1'b0;
		run = 1'b0;
		st = '0;
		prev_a = 8'h00;
		prev_b = 8'h00;
		mismatches = 0;
		check_count = 0;
		void'($urandom(32'h84cc));
		@(posedge CLK);
		run <= 1'b1;
		repeat (2) @(posedge CLK);
		for (int i = 0; i < 3000; i++) begin
			@(posedge CLK);
			NRST <= !(i > 1500 && i < 1504);
			st <= {$urandom(), $urandom(), $urandom()};
		end
		for (int i = 0; i < 24; i++) begin
			aq.push_back((i < 2) ? {8{i[0]}} : 8'($urandom()));
			put_addr(aq[i]);
			st.wr <= 1'b1;
			st.wdata <= 8'($urandom());
			@(negedge CLK);
			exp_mem[aq[i]] = st.wdata;
			@(posedge CLK);
			st.wr <= 1'b0;
		end
		foreach (aq[i]) begin
			put_addr(aq[i]);
			rd <= 1'b1;
			@(negedge CLK);
			cmp("read data", exp_mem[aq[i]], MEM_RDATA);
			cmp("bus address", aq[i], bus_addr);
			@(posedge CLK);
			rd <= 1'b0;
		end
		@(posedge CLK);
		tally_and_finish();
	end
endmodule : tb
